// ===== design/epjc_pkg.sv
// package: register map, field layout and bus types of the port j block
package epjc_pkg;
	localparam int          EPJC_PINS          = 8;
	localparam logic [7:0]  EPJC_OFS_DATA      = 8'h00;
	localparam logic [7:0]  EPJC_OFS_OUT_EN    = 8'h04;
	localparam logic [7:0]  EPJC_OFS_FUNC      = 8'h08;
	localparam logic [7:0]  EPJC_OFS_OPEN_DR   = 8'h28;
	localparam logic [7:0]  EPJC_OFS_PULL_UP   = 8'h2C;
	localparam logic [7:0]  EPJC_OFS_PULL_DN   = 8'h30;
	localparam logic [7:0]  EPJC_OFS_IN_EN     = 8'h38;
	localparam logic [7:0]  EPJC_RST_BYTE      = 8'h00;
	localparam logic [7:0]  EPJC_FUNC_MASK     = 8'hC0;
	localparam int          EPJC_BIT_IRQ_D     = 7;
	localparam int          EPJC_BIT_IRQ_C     = 6;
	localparam logic [1:0]  EPJC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  EPJC_HTRANS_SEQ    = 2'h3;

	typedef struct packed {
		logic [7:0] out_en;
		logic [7:0] open_dr;
		logic [7:0] pull_up;
		logic [7:0] pull_dn;
	} epjc_pad_cfg_t;
endpackage

// ===== design/epjc_pad_ctrl.sv
// module: per-pin pad drive, input gating and interrupt routing of port j
`timescale 1ns/100ps
module epjc_pad_ctrl
	import epjc_pkg::*;
(
	input  wire logic [7:0]    data_out,
	input  wire epjc_pad_cfg_t cfg,
	input  wire logic [7:0]    input_en,
	input  wire logic [7:0]    func_sel,
	input  wire logic          deep_stop,
	input  wire logic          stop_pin_drive_keep,
	input  wire logic [7:0]    pin_in,
	output logic [7:0]         pin_out,
	output logic [7:0]         pin_oe,
	output logic [7:0]         pin_pull_up,
	output logic [7:0]         pin_pull_dn,
	output logic [7:0]         pin_in_gated,
	output logic               ext_irq_line_d,
	output logic               ext_irq_line_c
);
	logic drive_allowed;
	assign drive_allowed = !deep_stop || stop_pin_drive_keep;

	genvar gi;
	for (gi = 0; gi < EPJC_PINS; gi++) begin : g_pin
		// open drain only ever pulls low; a high level floats
		assign pin_out[gi]      = cfg.open_dr[gi] ? 1'b0 : data_out[gi];
		assign pin_oe[gi]       = drive_allowed && cfg.out_en[gi]
		                          && !(cfg.open_dr[gi] && data_out[gi]);
		assign pin_pull_up[gi]  = cfg.pull_up[gi];
		assign pin_pull_dn[gi]  = cfg.pull_dn[gi];
		assign pin_in_gated[gi] = input_en[gi] && pin_in[gi];
	end

	// outside deep stop the input enable alone opens the path; in deep stop the function bit is needed too
	assign ext_irq_line_d = pin_in_gated[EPJC_BIT_IRQ_D]
	                        && (!deep_stop || func_sel[EPJC_BIT_IRQ_D]);
	assign ext_irq_line_c = pin_in_gated[EPJC_BIT_IRQ_C]
	                        && (!deep_stop || func_sel[EPJC_BIT_IRQ_C]);
endmodule // epjc_pad_ctrl

// ===== design/epjc_port_j.sv
// module: port j register file on an ahb-lite slave, with pad control
`timescale 1ns/100ps
module epjc_port_j
	import epjc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        deep_stop,
	input  wire logic        stop_pin_drive_keep,
	input  wire logic [7:0]  pin_in,
	output logic [7:0]       pin_out,
	output logic [7:0]       pin_oe,
	output logic [7:0]       pin_pull_up,
	output logic [7:0]       pin_pull_dn,
	output logic             ext_irq_line_d,
	output logic             ext_irq_line_c
);
	logic [7:0]    pin_data_reg_ff;
	logic [7:0]    output_enable_reg_ff;
	logic [7:0]    function_select_reg_ff;
	logic [7:0]    open_drain_reg_ff;
	logic [7:0]    pull_up_reg_ff;
	logic [7:0]    pull_down_reg_ff;
	logic [7:0]    input_enable_reg_ff;
	logic          wr_pend_ff;
	logic [7:0]    wr_addr_ff;
	logic [31:0]   rdata_ff;
	logic [31:0]   nxt_rdata;
	logic          acc_valid;
	logic [7:0]    pin_in_gated;
	logic [7:0]    wbyte;
	epjc_pad_cfg_t cfg;

	// zero wait states: the slave never stalls and always answers okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;
	assign acc_valid = hsel && hready && (htrans == EPJC_HTRANS_NONSEQ || htrans == EPJC_HTRANS_SEQ);
	assign wbyte     = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= acc_valid && hwrite;
			if (acc_valid)
				wr_addr_ff <= haddr[7:0];
		end
	end

	// one block per register; a write lands as its data phase ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pin_data_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_DATA)
			pin_data_reg_ff <= wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			output_enable_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_OUT_EN)
			output_enable_reg_ff <= wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			function_select_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_FUNC)
			function_select_reg_ff <= wbyte & EPJC_FUNC_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			open_drain_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_OPEN_DR)
			open_drain_reg_ff <= wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pull_up_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_PULL_UP)
			pull_up_reg_ff <= wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pull_down_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_PULL_DN)
			pull_down_reg_ff <= wbyte;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			input_enable_reg_ff <= EPJC_RST_BYTE;
		else if (wr_pend_ff && wr_addr_ff == EPJC_OFS_IN_EN)
			input_enable_reg_ff <= wbyte;
	end

	// data read: enabled inputs show the pin, others the latch
	always_comb begin
		nxt_rdata = rdata_ff;
		if (acc_valid && !hwrite) begin
			case (haddr[7:0])
			EPJC_OFS_DATA:    nxt_rdata = {24'h0000_00, (pin_in_gated & input_enable_reg_ff)
			                               | (pin_data_reg_ff & ~input_enable_reg_ff)};
			EPJC_OFS_OUT_EN:  nxt_rdata = {24'h0000_00, output_enable_reg_ff};
			EPJC_OFS_FUNC:    nxt_rdata = {24'h0000_00, function_select_reg_ff};
			EPJC_OFS_OPEN_DR: nxt_rdata = {24'h0000_00, open_drain_reg_ff};
			EPJC_OFS_PULL_UP: nxt_rdata = {24'h0000_00, pull_up_reg_ff};
			EPJC_OFS_PULL_DN: nxt_rdata = {24'h0000_00, pull_down_reg_ff};
			EPJC_OFS_IN_EN:   nxt_rdata = {24'h0000_00, input_enable_reg_ff};
			default:          nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= nxt_rdata;
	end

	assign cfg = '{out_en:  output_enable_reg_ff,
	               open_dr: open_drain_reg_ff,
	               pull_up: pull_up_reg_ff,
	               pull_dn: pull_down_reg_ff};

	epjc_pad_ctrl u_pad (
		.data_out            (pin_data_reg_ff),
		.cfg                 (cfg),
		.input_en            (input_enable_reg_ff),
		.func_sel            (function_select_reg_ff),
		.deep_stop           (deep_stop),
		.stop_pin_drive_keep (stop_pin_drive_keep),
		.pin_in              (pin_in),
		.pin_out             (pin_out),
		.pin_oe              (pin_oe),
		.pin_pull_up         (pin_pull_up),
		.pin_pull_dn         (pin_pull_dn),
		.pin_in_gated        (pin_in_gated),
		.ext_irq_line_d      (ext_irq_line_d),
		.ext_irq_line_c      (ext_irq_line_c)
	);

	a_write_data: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_DATA |=> pin_data_reg_ff == $past(hwdata[7:0]))
		else $error("data write not stored");
	a_oe_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_oe & ~output_enable_reg_ff) == 8'h00)
		else $error("pin driven while output disabled");
	a_write_oe: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_OUT_EN |=> output_enable_reg_ff == $past(hwdata[7:0]))
		else $error("output enable write not stored");
	a_open_drain: assert property (@(posedge hclk) disable iff (!hresetn)
		(open_drain_reg_ff & pin_oe & (pin_out | pin_data_reg_ff)) == 8'h00)
		else $error("open drain drove high");
	a_write_od: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_OPEN_DR |=> open_drain_reg_ff == $past(hwdata[7:0]))
		else $error("open drain write not stored");
	a_push_pull: assert property (@(posedge hclk) disable iff (!hresetn)
		!deep_stop && output_enable_reg_ff[2] && !open_drain_reg_ff[2] |-> pin_oe[2] && pin_out[2] == pin_data_reg_ff[2])
		else $error("push-pull pin not driven");
	a_pull_up: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_PULL_UP |=> pin_pull_up == $past(hwdata[7:0]))
		else $error("pull-up not applied");
	a_pull_dn: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_PULL_DN |=> pin_pull_dn == $past(hwdata[7:0]))
		else $error("pull-down not applied");
	a_func_low: assert property (@(posedge hclk) disable iff (!hresetn)
		function_select_reg_ff[5:0] == 6'h00)
		else $error("function low bits not zero");
	a_func_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_FUNC |=> function_select_reg_ff == ($past(hwdata[7:0]) & EPJC_FUNC_MASK))
		else $error("function write not stored");
	a_in_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!input_enable_reg_ff[7] |-> !ext_irq_line_d)
		else $error("irq passed with input disabled");
	a_irq_c_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!input_enable_reg_ff[6] |-> !ext_irq_line_c)
		else $error("irq c passed with input disabled");
	a_write_in_en: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_ff && wr_addr_ff == EPJC_OFS_IN_EN |=> input_enable_reg_ff == $past(hwdata[7:0]))
		else $error("input enable write not stored");
	a_stop_wake: assert property (@(posedge hclk) disable iff (!hresetn)
		deep_stop && input_enable_reg_ff[6] && function_select_reg_ff[6] |-> ext_irq_line_c == pin_in[6])
		else $error("deep stop wake blocked");
	a_stop_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		deep_stop && !stop_pin_drive_keep |-> pin_oe == 8'h00)
		else $error("pin driven in deep stop");
	a_run_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		!deep_stop && input_enable_reg_ff[7] |-> ext_irq_line_d == pin_in[7])
		else $error("irq not passed outside deep stop");
	a_read_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		acc_valid && !hwrite && haddr[7:0] == EPJC_OFS_DATA && input_enable_reg_ff == 8'hFF
		|=> hrdata == {24'h0000_00, $past(pin_in)})
		else $error("data read not the pin level");
	a_read_latch: assert property (@(posedge hclk) disable iff (!hresetn)
		acc_valid && !hwrite && haddr[7:0] == EPJC_OFS_DATA && input_enable_reg_ff == 8'h00
		|=> hrdata == {24'h0000_00, $past(pin_data_reg_ff)})
		else $error("data read not the written value");
endmodule // epjc_port_j

// ===== bench/epjc_board.sv
// board model: resolves each port j pin from pad drive, board drivers and pulls
`timescale 1ns/100ps
module epjc_board (
	input  wire logic       hclk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pull_up,
	input  wire logic [7:0] pin_pull_dn,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic [7:0]      pin_in
);
	logic [7:0] float_ff = 8'h55;
	// a floating pin toggles so a stale level never passes for a real one
	always_ff @(posedge hclk) begin
		float_ff <= ~float_ff;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_pull_up[i] | pin_pull_dn[i])
				pin_in[i] = pin_pull_up[i];
			else
				pin_in[i] = float_ff[i];
		end
	end
endmodule // epjc_board

// ===== bench/eight_bit_port_j_control_bench.sv
// testbench: register access, pad drive and interrupt routing of port j
`timescale 1ns/100ps
module eight_bit_port_j_control_bench import epjc_pkg::*;;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, deep_stop = 0, keep = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic        hreadyout, hresp, irq_d, irq_c;
	logic [7:0]  pin_in, pin_out, pin_oe, pu, pd, ext_en = 0, ext_val = 0;
	int          n_mismatch = 0, checks_done = 0;
	logic [7:0]  r_ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h28, 8'h2C, 8'h30, 8'h14};
	logic [31:0] r_wr  [7] = '{32'hFFFF_FF3C, 32'h0000_00A5, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
	                           32'h0000_000F, 32'h0000_00F0, 32'hFFFF_FFFF};
	logic [31:0] r_exp [7] = '{32'h0000_003C, 32'h0000_00A5, 32'h0000_00C0, 32'h0000_00FF,
	                           32'h0000_000F, 32'h0000_00F0, 32'h0000_0000};
	always #2 hclk = ~hclk;
	epjc_port_j i_epjc_port_j (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .deep_stop(deep_stop),
		.stop_pin_drive_keep(keep), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_up(pu), .pin_pull_dn(pd), .ext_irq_line_d(irq_d), .ext_irq_line_c(irq_c));
	epjc_board i_epjc_board (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pu),
		.pin_pull_dn(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= EPJC_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("response", 32'h0000_0001, {30'h0, hresp, hreadyout});
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task settle();
		repeat (3) @(posedge hclk);
		#1;
	endtask
	task give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge hclk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, r_ofs[i], r_wr[i]);
			bus(1'b0, r_ofs[i], 32'h0);
			chk("register", r_exp[i], rd);
		end
		settle();
		chk("oe open drain", 32'(8'h81), 32'(pin_oe));
		chk("pulls", 32'h0000_0FF0, {16'h0, pu, pd});
		bus(1'b1, EPJC_OFS_OPEN_DR, 32'h0);
		settle();
		chk("push pull", 32'h0000_A53C, {16'h0, pin_oe, pin_out});
		bus(1'b1, EPJC_OFS_OUT_EN, 32'h0);
		bus(1'b1, EPJC_OFS_FUNC, 32'h0);
		bus(1'b1, EPJC_OFS_IN_EN, 32'h0000_00FF);
		ext_en <= 8'hFF;
		ext_val <= 8'h96;
		settle();
		bus(1'b0, EPJC_OFS_DATA, 32'h0);
		chk("pin read", 32'h0000_0096, rd);
		chk("irq run", 32'h2, {irq_d, irq_c});
		deep_stop <= 1'b1;
		settle();
		chk("irq stop nofunc", 32'h0, {irq_d, irq_c});
		bus(1'b1, EPJC_OFS_FUNC, 32'h0000_00C0);
		ext_val <= 8'h40;
		settle();
		chk("irq stop func", 32'h1, {irq_d, irq_c});
		bus(1'b1, EPJC_OFS_OUT_EN, 32'h0000_00FF);
		ext_en <= 8'h00;
		settle();
		chk("stop no drive", 32'h0, 32'(pin_oe));
		@(posedge hclk);
		keep <= 1'b1;
		settle();
		chk("stop keep drive", 32'h0000_00FF, 32'(pin_oe));
		@(posedge hclk);
		deep_stop <= 1'b0;
		hresetn <= 1'b0;
		settle();
		chk("reset pins", 32'h0, {pin_oe, pu, pd, 6'h0, irq_d, irq_c});
		@(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, r_ofs[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		bus(1'b0, EPJC_OFS_IN_EN, 32'h0);
		chk("reset input en", 32'h0, rd);
		give_verdict();
	end
endmodule // eight_bit_port_j_control_bench
